// ===== arp_pkg.sv
// Shared constants and types for the converter result output port
package arp_pkg;

	// ******************************
	// Widths
	// ******************************
	localparam int RESULT_W  = 14;
	localparam int BUS_W     = 16;
	localparam int BYTE_W    = 8;
	localparam int CHANNELS  = 8;
	localparam int FIFO_DEPTH = 32;

	// ******************************
	// Pin positions on the result lines
	// ******************************
	localparam int POS_BYTE_SEL = 15;   // Byte-mode select when interface select high
	localparam int POS_HBF      = 14;   // High-byte-first input when interface select high
	localparam int POS_SER_A    = 7;    // First serial output
	localparam int POS_SER_B    = 8;    // Second serial output

	// ******************************
	// Reset values and counts
	// ******************************
	localparam logic [13:0] RESULT_RST  = 14'h0000;
	localparam logic [15:0] BUS_RST     = 16'h0000;
	localparam logic [3:0]  SER_BITS    = 4'hE;    // Bits per serial word

	// Port operating modes
	typedef enum logic [1:0] {
		ARP_MODE_PAR,
		ARP_MODE_BYTE,
		ARP_MODE_SER
	} arp_mode_t;

endpackage

// ===== arp_fifo.sv
// Result FIFO with valid and ready on both sides
`timescale 1ns/1ps

module arp_fifo #(
	parameter int WIDTH = 14,
	parameter int DEPTH = 32
) (
	// Clock and reset
	input  wire logic             mclk,
	input  wire logic             srst,
	// Fill side
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	// Drain side
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic [WIDTH-1:0]      out_data
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ptr_ff;
	logic [AW-1:0]    rd_ptr_ff;
	logic [AW:0]      count_ff;
	logic             push;
	logic             pop;

	assign in_ready  = (count_ff != (AW+1)'(DEPTH));
	assign out_valid = (count_ff != '0);
	assign out_data  = mem[rd_ptr_ff];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	// ******************************
	// Storage and pointers
	// ******************************
	// Storage needs no reset; only pointers define contents
	always_ff @(posedge mclk) begin
		if (push) begin
			mem[wr_ptr_ff] <= in_data;
		end
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			wr_ptr_ff <= '0;
			rd_ptr_ff <= '0;
			count_ff  <= '0;
		end else begin
			if (push) begin
				wr_ptr_ff <= (wr_ptr_ff == AW'(DEPTH-1)) ? '0 : wr_ptr_ff + 1'b1;
			end
			if (pop) begin
				rd_ptr_ff <= (rd_ptr_ff == AW'(DEPTH-1)) ? '0 : rd_ptr_ff + 1'b1;
			end
			count_ff <= count_ff + (AW+1)'(push) - (AW+1)'(pop);
		end
	end

	a_fifo_no_overflow: assert property (@(posedge mclk) disable iff (srst)
		count_ff <= (AW+1)'(DEPTH))
		else $error("FIFO count above depth");

endmodule // arp_fifo

// ===== arp_port.sv
// Converter result output port: parallel, byte and serial modes
`timescale 1ns/1ps

// Notes on behaviour
// - With interface select low the low data lines carry result bits 13..0 while select and read are low.
// - In full parallel mode lines 14 and 15 are copies of result bit 13.
// - Interface select high with byte select low gives serial mode.
// - Interface select high makes line 15 the byte select input; high gives byte mode.
// - Byte mode delivers one result in two read strobes on eight lines; the host does both reads.
// - In byte mode line 7 is the byte MSB and line 0 its LSB.
// - In byte mode high-byte-first 1 sends the upper byte first, 0 the lower byte first.
// - Serial mode uses line 7 as first and line 8 as second serial output.
// - New results are latched into output registers on the busy falling edge.
// - A reset during a read clears the output registers to zero.
// - In parallel mode the first-channel flag rises on the read edge of channel 1 and falls on the next.
// - Serial mode shows the MSB at select fall and shifts on each serial clock rise.
module arp_port #(
	parameter int RESULT_W = arp_pkg::RESULT_W,
	parameter int CHANNELS = arp_pkg::CHANNELS,
	parameter int DEPTH    = arp_pkg::FIFO_DEPTH
) (
	// Clock and reset
	input  wire logic                 mclk,
	input  wire logic                 srst,
	// Conversion core side
	input  wire logic                 busy,
	input  wire logic [RESULT_W-1:0]  conv_a_data,
	input  wire logic [RESULT_W-1:0]  conv_b_data,
	input  wire logic                 conv_valid,
	output logic                      conv_ready,
	// Host pins
	input  wire logic                 interface_select,
	input  wire logic                 cs_n,
	input  wire logic                 rd_sclk,
	input  wire logic [15:0]          parallel_result_lines_in,
	output logic [15:0]               parallel_result_lines_out,
	output logic [15:0]               parallel_result_lines_oe,
	output logic                      first_channel_flag_out,
	output logic                      first_channel_flag_oe
);
	localparam int CW = $clog2(CHANNELS);

	// ******************************
	// Pin synchronisers
	// ******************************
	logic [4:0] sync1_ff;
	logic [4:0] sync2_ff;
	always_ff @(posedge mclk) begin
		sync1_ff <= {parallel_result_lines_in[arp_pkg::POS_BYTE_SEL],
			parallel_result_lines_in[arp_pkg::POS_HBF], interface_select, cs_n, rd_sclk};
		sync2_ff <= sync1_ff;
	end
	logic byte_sel_s, hbf_s, isel_s, cs_s, clk_s;
	assign {byte_sel_s, hbf_s, isel_s, cs_s, clk_s} = sync2_ff;

	logic cs_d_ff, clk_d_ff, busy_d_ff;
	always_ff @(posedge mclk) begin
		if (srst) begin
			cs_d_ff   <= 1'b1;
			clk_d_ff  <= 1'b1;
			busy_d_ff <= 1'b0;
		end else begin
			cs_d_ff   <= cs_s;
			clk_d_ff  <= clk_s;
			busy_d_ff <= busy;
		end
	end
	logic cs_fall, clk_fall, clk_rise, rd_rise, busy_fall;
	assign cs_fall   = cs_d_ff && !cs_s;
	assign clk_fall  = clk_d_ff && !clk_s && !cs_s;
	assign clk_rise  = !clk_d_ff && clk_s && !cs_s;
	// Read release may come together with select release, so select is taken one cycle back
	assign rd_rise   = !clk_d_ff && clk_s && !cs_d_ff;
	assign busy_fall = busy_d_ff && !busy;

	// Mode decode; host keeps the inputs steady during a read
	arp_pkg::arp_mode_t mode;
	always_comb begin
		if (!isel_s) begin
			mode = arp_pkg::ARP_MODE_PAR;
		end else if (byte_sel_s) begin
			mode = arp_pkg::ARP_MODE_BYTE;
		end else begin
			mode = arp_pkg::ARP_MODE_SER;
		end
	end

	// ******************************
	// Result FIFO: pairs of results from the core
	// ******************************
	logic                    pop_ready;
	logic                    fifo_valid;
	logic [2*RESULT_W-1:0]   fifo_data;
	arp_fifo #(.WIDTH(2*RESULT_W), .DEPTH(DEPTH)) u_fifo (
		.mclk      (mclk),
		.srst      (srst),
		.in_valid  (conv_valid),
		.in_ready  (conv_ready),
		.in_data   ({conv_a_data, conv_b_data}),
		.out_valid (fifo_valid),
		.out_ready (pop_ready),
		.out_data  (fifo_data)
	);

	// ******************************
	// Output registers: one result per channel
	// ******************************
	logic [RESULT_W-1:0] res_ff [CHANNELS];
	logic [CW-1:0]       wr_ch_ff;
	logic                read_active;
	// A pair is drained only on busy falling, so a read sees a stable set
	assign pop_ready   = busy_fall && fifo_valid;
	assign read_active = !cs_s;
	always_ff @(posedge mclk) begin
		if (srst) begin
			wr_ch_ff <= '0;
			for (int i = 0; i < CHANNELS; i++) begin
				res_ff[i] <= arp_pkg::RESULT_RST;
			end
		end else if (pop_ready) begin
			// Pair goes to channel n and n+CHANNELS/2
			res_ff[wr_ch_ff]                    <= fifo_data[2*RESULT_W-1:RESULT_W];
			res_ff[wr_ch_ff + CW'(CHANNELS/2)] <= fifo_data[RESULT_W-1:0];
			wr_ch_ff <= (wr_ch_ff == CW'(CHANNELS/2-1)) ? '0 : wr_ch_ff + 1'b1;
		end
	end

	// ******************************
	// Read sequencing
	// ******************************
	logic [CW-1:0]       rd_ch_ff;
	logic                byte_phase_ff;
	logic [RESULT_W-1:0] shift_a_ff;
	logic [RESULT_W-1:0] shift_b_ff;
	logic [RESULT_W-1:0] cur;
	logic [3:0]          ser_cnt_ff;
	logic                first_ff;
	assign cur = res_ff[rd_ch_ff];

	// Byte phase advances per byte-mode strobe; channel pointer per parallel strobe, per second byte strobe or per serial word
	always_ff @(posedge mclk) begin
		if (srst || busy_fall) begin
			rd_ch_ff      <= '0;
			byte_phase_ff <= 1'b0;
			ser_cnt_ff    <= '0;
			first_ff      <= 1'b0;
		end else if (mode == arp_pkg::ARP_MODE_SER) begin
			if (cs_fall) begin
				ser_cnt_ff <= '0;
				first_ff   <= (rd_ch_ff == '0);
			end else if (clk_fall) begin
				ser_cnt_ff <= ser_cnt_ff + 4'h1;
				if (ser_cnt_ff == arp_pkg::SER_BITS - 4'h1) begin
					first_ff <= 1'b0;
					rd_ch_ff <= rd_ch_ff + 1'b1;
				end
			end
		end else if (clk_fall) begin
			// Flag follows the strobe that presents channel 1
			first_ff <= (rd_ch_ff == '0) && !byte_phase_ff;
		end else if (rd_rise) begin
			// Advance on release so the word stands for the whole strobe
			if (mode == arp_pkg::ARP_MODE_BYTE && !byte_phase_ff) begin
				byte_phase_ff <= 1'b1;
			end else begin
				byte_phase_ff <= 1'b0;
				rd_ch_ff      <= rd_ch_ff + 1'b1;
			end
		end
	end

	// Serial shifters: A walks channels 1..4, B channels 5..8
	always_ff @(posedge mclk) begin
		if (srst) begin
			shift_a_ff <= arp_pkg::RESULT_RST;
			shift_b_ff <= arp_pkg::RESULT_RST;
		end else if (cs_fall) begin
			shift_a_ff <= res_ff[rd_ch_ff];
			shift_b_ff <= res_ff[rd_ch_ff + CW'(CHANNELS/2)];
		end else if (clk_rise) begin
			shift_a_ff <= {shift_a_ff[RESULT_W-2:0], 1'b0};
			shift_b_ff <= {shift_b_ff[RESULT_W-2:0], 1'b0};
		end
	end

	// ******************************
	// Pin drivers, all registered
	// ******************************
	logic [15:0] nxt_out;
	logic [15:0] nxt_oe;
	logic [7:0]  byte_val;
	always_comb begin
		// Upper byte is sign extended from result bit 13
		byte_val = (hbf_s ^ byte_phase_ff) ? {{2{cur[13]}}, cur[13:8]} : cur[7:0];
		nxt_out  = arp_pkg::BUS_RST;
		nxt_oe   = arp_pkg::BUS_RST;
		unique case (mode)
			arp_pkg::ARP_MODE_PAR: begin
				nxt_out = {{2{cur[13]}}, cur};
				nxt_oe  = (cs_s || clk_s) ? 16'h0000 : 16'hFFFF;
			end
			arp_pkg::ARP_MODE_BYTE: begin
				nxt_out[7:0] = byte_val;
				nxt_oe[7:0]  = (cs_s || clk_s) ? 8'h00 : 8'hFF;
			end
			arp_pkg::ARP_MODE_SER: begin
				// Lines 13..9 are grounded by the board, so never driven
				nxt_out[arp_pkg::POS_SER_A] = shift_a_ff[RESULT_W-1];
				nxt_out[arp_pkg::POS_SER_B] = shift_b_ff[RESULT_W-1];
				nxt_oe[arp_pkg::POS_SER_A]  = !cs_s;
				nxt_oe[arp_pkg::POS_SER_B]  = !cs_s;
			end
		endcase
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			parallel_result_lines_out <= arp_pkg::BUS_RST;
			parallel_result_lines_oe  <= arp_pkg::BUS_RST;
			first_channel_flag_out    <= 1'b0;
			first_channel_flag_oe     <= 1'b0;
		end else begin
			parallel_result_lines_out <= nxt_out;
			parallel_result_lines_oe  <= nxt_oe;
			first_channel_flag_out    <= first_ff;
			first_channel_flag_oe     <= read_active;
		end
	end

	// ******************************
	// Checks
	// ******************************
	sequence s_strobe_low;
		!cs_s && !clk_s;
	endsequence

	a_par_float: assert property (@(posedge mclk) disable iff (srst)
		(mode == arp_pkg::ARP_MODE_PAR && (cs_s || clk_s)) |=>
		parallel_result_lines_oe == 16'h0000)
		else $error("Lines driven while strobes high");
	a_par_drive: assert property (@(posedge mclk) disable iff (srst)
		((mode == arp_pkg::ARP_MODE_PAR) and s_strobe_low) |=>
		parallel_result_lines_oe == 16'hFFFF)
		else $error("Parallel lines not driven");
	a_sign_ext: assert property (@(posedge mclk) disable iff (srst)
		$past(mode == arp_pkg::ARP_MODE_PAR) |->
		parallel_result_lines_out[15:14] == {2{parallel_result_lines_out[13]}})
		else $error("Sign extension wrong");
	a_byte_upper_float: assert property (@(posedge mclk) disable iff (srst)
		$past(mode == arp_pkg::ARP_MODE_BYTE) |-> parallel_result_lines_oe[15:8] == 8'h00)
		else $error("Upper lines driven in byte mode");
	a_ser_pins: assert property (@(posedge mclk) disable iff (srst)
		$past(mode == arp_pkg::ARP_MODE_SER) |->
		(parallel_result_lines_oe & 16'hFE7F) == 16'h0000)
		else $error("Non-serial lines driven in serial mode");
	a_ser_shift: assert property (@(posedge mclk) disable iff (srst)
		(mode == arp_pkg::ARP_MODE_SER && clk_rise && !cs_fall) |=>
		shift_a_ff == {$past(shift_a_ff[RESULT_W-2:0]), 1'b0})
		else $error("Serial shift missed");
	a_latch_busy: assert property (@(posedge mclk) disable iff (srst)
		(busy_fall && fifo_valid) |=>
		res_ff[$past(wr_ch_ff)] == $past(fifo_data[2*RESULT_W-1:RESULT_W]))
		else $error("Result not latched on busy fall");
	a_flag_float: assert property (@(posedge mclk) disable iff (srst)
		cs_s |=> !first_channel_flag_oe)
		else $error("Flag driven with select high");
	a_reset_clear: assert property (@(posedge mclk)
		srst |=> res_ff[0] == arp_pkg::RESULT_RST)
		else $error("Output register not cleared");

endmodule // arp_port

// ===== arp_host.sv
// Host model: drives the result port pins and reads results back
`timescale 1ns/1ps

module arp_host (
	// Clock
	input  wire logic        mclk,
	// Device pins
	input  wire logic [15:0] lines_out,
	input  wire logic [15:0] lines_oe,
	input  wire logic        flag_out,
	output logic             interface_select,
	output logic             cs_n,
	output logic             rd_sclk,
	output logic [15:0]      lines_in
);
	logic byte_sel;
	logic hbf;

	// Device drive wins; a released line shows the inverse so stale data cannot pass, except lines 15..9 (mode inputs and zeros) with interface select high
	always_comb begin
		for (int i = 0; i < 16; i++) begin
			if (lines_oe[i])
				lines_in[i] = lines_out[i];
			else if (interface_select && i >= 9)
				lines_in[i] = (i == 15) ? byte_sel : ((i == 14) ? hbf : 1'b0);
			else
				lines_in[i] = ~lines_out[i];
		end
	end

	// Idle pins at time zero
	initial begin
		interface_select = 1'b0;
		cs_n = 1'b1;
		rd_sclk = 1'b1;
		byte_sel = 1'b0;
		hbf = 1'b0;
	end

	// Mode pins change only between transfers
	task automatic set_mode(input logic sel, input logic bsel, input logic hb);
		@(posedge mclk);
		interface_select <= sel;
		byte_sel <= bsel;
		hbf <= hb;
		repeat (4) @(posedge mclk);
	endtask

	// One parallel strobe; three edges of latency, so sample well after
	task automatic strobe(output logic [15:0] d, output logic [15:0] oe, output logic f);
		@(posedge mclk);
		cs_n <= 1'b0;
		rd_sclk <= 1'b0;
		repeat (5) @(posedge mclk);
		@(negedge mclk);
		d = lines_in;
		oe = lines_oe;
		f = flag_out;
		@(posedge mclk);
		cs_n <= 1'b1;
		rd_sclk <= 1'b1;
		repeat (5) @(posedge mclk);
	endtask

	// Serial frame: slow clock, fourteen falls, bit sampled before each fall
	task automatic ser_read(output logic [13:0] a, output logic [13:0] b);
		@(posedge mclk);
		cs_n <= 1'b0;
		for (int i = 13; i >= 0; i--) begin
			repeat (5) @(posedge mclk);
			@(negedge mclk);
			a[i] = lines_in[7];
			b[i] = lines_in[8];
			@(posedge mclk);
			rd_sclk <= 1'b0;
			repeat (6) @(posedge mclk);
			rd_sclk <= 1'b1;
		end
		cs_n <= 1'b1;
		repeat (5) @(posedge mclk);
	endtask
endmodule // arp_host

// ===== tb_adc_result_output_port.sv
// Testbench for the converter result output port
`timescale 1ns/1ps

module tb_adc_result_output_port;
	logic        mclk, srst, busy, conv_valid, conv_ready, f;
	logic [13:0] conv_a_data, conv_b_data, v, sa, sb;
	logic [15:0] p_in, p_out, p_oe, d, d2, oe;
	logic        cs_n, rd_sclk, is_sel, fl_out, fl_oe;
	int          error_cnt, num_checks;

	// ****************************
	// Clock and instances
	// ****************************
	initial begin
		mclk = 1'b0;
		forever #50 mclk = ~mclk;
	end

	arp_port dut_u (.mclk(mclk), .srst(srst), .busy(busy), .conv_a_data(conv_a_data),
		.conv_b_data(conv_b_data), .conv_valid(conv_valid), .conv_ready(conv_ready),
		.interface_select(is_sel), .cs_n(cs_n), .rd_sclk(rd_sclk),
		.parallel_result_lines_in(p_in), .parallel_result_lines_out(p_out),
		.parallel_result_lines_oe(p_oe), .first_channel_flag_out(fl_out),
		.first_channel_flag_oe(fl_oe));

	arp_host host_u (.mclk(mclk), .lines_out(p_out), .lines_oe(p_oe), .flag_out(fl_out),
		.interface_select(is_sel), .cs_n(cs_n), .rd_sclk(rd_sclk), .lines_in(p_in));

	// ****************************
	// Tasks
	// ****************************
	task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
		num_checks++;
		if (got !== exp) begin
			$display("Error %s expected %h seen %h", what, exp, got);
			error_cnt++;
		end
	endtask

	task automatic report_and_stop;
		$display("Checks %0d mismatches %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// Channels 0..3 come from the a words of the last four pairs, 4..7 from b
	function automatic logic [13:0] ch_val(input logic [13:0] base, input int p, input int ch);
		logic [13:0] r;
		r = base + 14'(p - 4 + ch % 4);
		if (ch >= 4)
			r = r ^ 14'h2000;
		return r;
	endfunction

	// Offer n pairs (refused beyond the FIFO depth), then one busy fall per pair
	task automatic load(input int n, input logic [13:0] base);
		int got;
		got = 0;
		for (int c = 0; c < 200 && got < n; c++) begin
			@(posedge mclk);
			conv_a_data <= base + 14'(got);
			conv_b_data <= (base + 14'(got)) ^ 14'h2000;
			conv_valid <= 1'b1;
			@(negedge mclk);
			if (conv_ready === 1'b1)
				got++;
		end
		@(posedge mclk);
		conv_valid <= 1'b0;
		check("pairs taken", 16'((n > 32) ? 32 : n), 16'(got));
		for (int i = 0; i < got; i++) begin
			@(posedge mclk);
			busy <= 1'b1;
			repeat (2) @(posedge mclk);
			busy <= 1'b0;
			repeat (3) @(posedge mclk);
		end
	endtask

	// ****************************
	// Test sequence
	// ****************************
	initial begin
		{srst, busy, conv_valid, conv_a_data, conv_b_data} = {1'b1, 30'h0};
		error_cnt = 0;
		num_checks = 0;
		repeat (20) @(posedge mclk);
		srst <= 1'b0;
		repeat (4) @(posedge mclk);
		check("oe after reset", 16'h0000, p_oe);
		load(33, 14'h2A50);
		for (int ch = 0; ch < 8; ch++) begin
			host_u.strobe(d, oe, f);
			v = ch_val(14'h2A50, 32, ch);
			check("parallel word", {v[13], v[13], v}, d);
			check("parallel oe", 16'hFFFF, oe);
			check("first flag", 16'(ch == 0), 16'(f));
			check("released oe", 16'h0000, p_oe);
			check("released flag oe", 16'h0000, 16'(fl_oe));
		end
		$display("Test parallel done");
		for (int hb = 0; hb < 2; hb++) begin
			host_u.set_mode(1'b1, 1'b1, hb[0]);
			load(4, 14'h1234 + 14'(hb * 16'h0900));
			for (int ch = 0; ch < 8; ch++) begin
				host_u.strobe(d, oe, f);
				host_u.strobe(d2, oe, f);
				v = ch_val(14'h1234 + 14'(hb * 16'h0900), 4, ch);
				check("byte one", 16'(hb ? {{2{v[13]}}, v[13:8]} : v[7:0]), 16'(d[7:0]));
				check("byte two", 16'(hb ? v[7:0] : {{2{v[13]}}, v[13:8]}), 16'(d2[7:0]));
			end
		end
		$display("Test byte done");
		host_u.set_mode(1'b1, 1'b0, 1'b0);
		load(4, 14'h0C3A);
		for (int k = 0; k < 4; k++) begin
			host_u.ser_read(sa, sb);
			check("serial first", 16'(ch_val(14'h0C3A, 4, k)), 16'(sa));
			check("serial second", 16'(ch_val(14'h0C3A, 4, k + 4)), 16'(sb));
		end
		$display("Test serial done");
		host_u.set_mode(1'b0, 1'b0, 1'b0);
		load(4, 14'h1555);
		fork
			host_u.strobe(d, oe, f);
			begin
				repeat (3) @(posedge mclk);
				srst <= 1'b1;
				@(posedge mclk);
				srst <= 1'b0;
			end
		join
		host_u.strobe(d, oe, f);
		check("cleared word", 16'h0000, d);
		check("cleared oe", 16'hFFFF, oe);
		$display("Test reset read done");
		report_and_stop();
	end
endmodule // tb_adc_result_output_port
